/* File: common/dpc_defs.svh */
/*
  Constants for the dual pipe dependency control: register file sizes,
  in-flight window depth and reset mapping.
  Assumes inclusion by bare name from design files only.
*/
`ifndef DPC_DEFS_SVH
`define DPC_DEFS_SVH

// Physical and architectural register counts
`define DPC_NUM_PHYS 32
`define DPC_NUM_ARCH 8
`define DPC_LREG_W 3

// In-flight window, in program order
`define DPC_ROB_DEPTH 8

// Reset mapping: logical register i sits in physical register i
`define DPC_RST_FREE_MASK 32'hFFFF_FF00

`endif

/* File: common/dpc_pkg.sv */
/*
  Types shared by the dual pipe dependency control and its bench:
  instruction kinds and the decoded slot handed over by decode.
  Assumes the decoder fills every field of a valid slot.
*/
`default_nettype none

package dpc_pkg;

  // Kinds the decoder tags each instruction with
  typedef enum logic [3:0] {
    DPC_K_ALU = 4'h0,
    DPC_K_MOVE = 4'h1,
    DPC_K_BRANCH = 4'h2,
    DPC_K_FP = 4'h3,
    DPC_K_SEG_LOAD = 4'h4,
    DPC_K_SPEC_REG = 4'h5,
    DPC_K_STRING = 4'h6,
    DPC_K_MULDIV = 4'h7,
    DPC_K_IO_PORT = 4'h8,
    DPC_K_PUSH_POP_ALL = 4'h9,
    DPC_K_FAR_XFER = 4'hA
  } dpc_kind_t;

  // One decoded instruction; widths are opaque size codes
  typedef struct packed {
    logic vld;
    dpc_kind_t kind;
    logic dst_vld;
    logic [2:0] dst;
    logic [1:0] dst_w;
    logic src_a_vld;
    logic [2:0] src_a;
    logic [1:0] src_w;
    logic src_b_vld;
    logic [2:0] src_b;
  } dpc_slot_t;

endpackage

`default_nettype wire

/* File: rtl/dpc_dual_pipe_ctrl.sv */
/*
  Dual pipe issue and completion control: staging of decoded pairs,
  X/Y steering and pairing, register renaming over a physical file,
  operand/result forwarding, interlocks, and an in-order commit window.
  Assumes one clock, decode handing over pairs on a ready handshake,
  and the execute units reporting completion by window tag.
*/
`default_nettype none
`include "dpc_defs.svh"

module dpc_dual_pipe_ctrl #(
  parameter int NPHYS = `DPC_NUM_PHYS,
  parameter int DEPTH = `DPC_ROB_DEPTH
) (
  input wire logic i_clk,
  input wire logic i_rst,
  input wire logic i_pair_valid,
  input wire dpc_pkg::dpc_slot_t i_slot0,
  input wire dpc_pkg::dpc_slot_t i_slot1,
  output logic o_ready,
  input wire logic i_x_done,
  input wire logic [$clog2(DEPTH)-1:0] i_x_tag,
  input wire logic i_x_exc,
  input wire logic i_y_done,
  input wire logic [$clog2(DEPTH)-1:0] i_y_tag,
  input wire logic i_y_exc,
  output logic o_x_issue,
  output logic [$clog2(DEPTH)-1:0] o_x_tag,
  output logic [$clog2(NPHYS)-1:0] o_x_pdst,
  output logic [$clog2(NPHYS)-1:0] o_x_psrc_a,
  output logic [$clog2(NPHYS)-1:0] o_x_psrc_b,
  output logic o_x_excl,
  output logic o_y_issue,
  output logic [$clog2(DEPTH)-1:0] o_y_tag,
  output logic [$clog2(NPHYS)-1:0] o_y_pdst,
  output logic [$clog2(NPHYS)-1:0] o_y_psrc_a,
  output logic [$clog2(NPHYS)-1:0] o_y_psrc_b,
  output logic o_y_opfwd,
  output logic o_y_resfwd,
  output logic o_cmt_valid,
  output logic o_cmt_wr,
  output logic [`DPC_LREG_W-1:0] o_cmt_lreg,
  output logic [$clog2(NPHYS)-1:0] o_cmt_pdst,
  output logic o_cmt_exc,
  output logic o_flush
);

  localparam int PW = $clog2(NPHYS);
  localparam int TW = $clog2(DEPTH);
  localparam int NA = `DPC_NUM_ARCH;

  // Renaming needs room beyond the architectural set; window is a ring
  initial
  begin
    if (NPHYS != `DPC_NUM_PHYS || DEPTH < 2 || (DEPTH & (DEPTH - 1)) != 0)
      $error("dpc_dual_pipe_ctrl: unsupported NPHYS or DEPTH");
  end

  typedef struct packed {
    logic vld;
    logic done;
    logic exc;
    logic wr;
    logic [`DPC_LREG_W-1:0] lreg;
    logic [PW-1:0] pnew;
    logic [PW-1:0] pold;
  } dpc_rob_t;

  typedef struct packed {
    dpc_pkg::dpc_slot_t s0;
    dpc_pkg::dpc_slot_t s1;
    logic rdy;
    logic [NA-1:0][PW-1:0] map;
    logic [NA-1:0][PW-1:0] cmap;
    logic [NPHYS-1:0] free;
    logic [NPHYS-1:0] pready;
    dpc_rob_t [DEPTH-1:0] rob;
    logic [TW-1:0] head;
    logic [TW-1:0] tail;
    logic [TW:0] cnt;
    logic x_issue;
    logic [PW-1:0] x_pdst;
    logic [PW-1:0] x_psa;
    logic [PW-1:0] x_psb;
    logic x_excl;
    logic y_issue;
    logic [PW-1:0] y_pdst;
    logic [PW-1:0] y_psa;
    logic [PW-1:0] y_psb;
    logic y_opfwd;
    logic y_resfwd;
    logic [TW-1:0] x_tag;
    logic [TW-1:0] y_tag;
    logic cmt_valid;
    logic cmt_wr;
    logic [`DPC_LREG_W-1:0] cmt_lreg;
    logic [PW-1:0] cmt_pdst;
    logic cmt_exc;
    logic flush;
  } dpc_state_t;

  dpc_state_t s_ff;
  dpc_state_t nxt_s;

  function automatic logic is_excl(input dpc_pkg::dpc_kind_t k);
    is_excl = k inside {dpc_pkg::DPC_K_SEG_LOAD, dpc_pkg::DPC_K_SPEC_REG,
      dpc_pkg::DPC_K_STRING, dpc_pkg::DPC_K_MULDIV, dpc_pkg::DPC_K_IO_PORT,
      dpc_pkg::DPC_K_PUSH_POP_ALL, dpc_pkg::DPC_K_FAR_XFER};
  endfunction

  function automatic logic x_only(input dpc_pkg::dpc_kind_t k);
    x_only = is_excl(k) || k == dpc_pkg::DPC_K_BRANCH ||
      k == dpc_pkg::DPC_K_FP;
  endfunction

  // Completion, commit, forwarding and dispatch in one pass
  always_comb
  begin
    dpc_pkg::dpc_slot_t x;
    dpc_pkg::dpc_slot_t y;
    dpc_rob_t h;
    logic [PW-1:0] f0;
    logic [PW-1:0] f1;
    logic [1:0] fcnt;
    logic [NPHYS-1:0] used;
    logic [PW-1:0] xa;
    logic [PW-1:0] xb;
    logic [PW-1:0] ya;
    logic [PW-1:0] yb;
    logic [PW-1:0] xd;
    logic [PW-1:0] yd;
    logic dep_a;
    logic dep_b;
    logic opf;
    logic resf;
    logic x_go;
    logic y_go;
    logic y_ok;
    logic [1:0] need;
    logic [TW-1:0] t1;
    x = s_ff.s0;
    y = s_ff.s1;
    h = s_ff.rob[s_ff.head];
    f0 = '0;
    f1 = '0;
    fcnt = 2'h0;
    used = '0;
    dep_a = 1'b0;
    dep_b = 1'b0;
    opf = 1'b0;
    resf = 1'b0;
    y_ok = 1'b0;
    x_go = 1'b0;
    y_go = 1'b0;
    need = 2'h0;
    t1 = s_ff.tail + 1'b1;
    nxt_s = s_ff;
    nxt_s.x_issue = 1'b0;
    nxt_s.y_issue = 1'b0;
    nxt_s.cmt_valid = 1'b0;
    nxt_s.flush = 1'b0;

    // completions marked by tag in any order
    if (i_x_done)
    begin
      nxt_s.rob[i_x_tag].done = 1'b1;
      nxt_s.rob[i_x_tag].exc = i_x_exc;
      if (s_ff.rob[i_x_tag].wr)
        nxt_s.pready[s_ff.rob[i_x_tag].pnew] = 1'b1;
    end
    if (i_y_done)
    begin
      nxt_s.rob[i_y_tag].done = 1'b1;
      nxt_s.rob[i_y_tag].exc = i_y_exc;
      if (s_ff.rob[i_y_tag].wr)
        nxt_s.pready[s_ff.rob[i_y_tag].pnew] = 1'b1;
    end

    // Lowest two free physical registers
    for (int i = 0; i < NPHYS; i++)
    begin
      if (s_ff.free[i] && fcnt == 2'h0)
      begin
        f0 = PW'(i);
        fcnt = 2'h1;
      end
      else if (s_ff.free[i] && fcnt == 2'h1)
      begin
        f1 = PW'(i);
        fcnt = 2'h2;
      end
    end

    // Source lookups; pair dependences seen by logical name
    xa = s_ff.map[x.src_a];
    xb = s_ff.map[x.src_b];
    ya = s_ff.map[y.src_a];
    yb = s_ff.map[y.src_b];
    dep_a = y.src_a_vld && x.dst_vld && y.src_a == x.dst;
    dep_b = y.src_b_vld && x.dst_vld && y.src_b == x.dst;
    xd = f0;
    yd = x.dst_vld ? f1 : f0;

    // older must be move-type; widths match
    // source may be register or memory alike
    opf = (dep_a || dep_b) && x.kind == dpc_pkg::DPC_K_MOVE &&
      x.dst_w == y.src_w;
    // younger is a move; both destinations take the result
    resf = (dep_a || dep_b) && !opf && y.kind == dpc_pkg::DPC_K_MOVE;

    // interlock on unready sources; stall without free regs
    x_go = x.vld && s_ff.cnt < (TW+1)'(DEPTH) &&
      (!x.src_a_vld || s_ff.pready[xa]) &&
      (!x.src_b_vld || s_ff.pready[xb]) &&
      (!x.dst_vld || fcnt != 2'h0);

    // WAR and WAW ignored here, renaming resolves them
    // pair RAW only passes with forwarding
    y_ok = (dep_a ? (opf || resf) : (!y.src_a_vld || s_ff.pready[ya])) &&
      (dep_b ? (opf || resf) : (!y.src_b_vld || s_ff.pready[yb]));
    need = {1'b0, x.dst_vld} + {1'b0, y.dst_vld};
    // Y never takes X-only kinds; branch or FP may pair
    // nothing pairs with an exclusive instruction
    y_go = x_go && y.vld && !x_only(y.kind) && !is_excl(x.kind) && y_ok &&
      s_ff.cnt < (TW+1)'(DEPTH - 1) && fcnt >= need;

    // commit oldest only, in program order
    if (h.vld && h.done)
    begin
      nxt_s.cmt_valid = 1'b1;
      nxt_s.cmt_exc = h.exc;
      nxt_s.cmt_wr = h.wr && !h.exc;
      nxt_s.cmt_lreg = h.lreg;
      nxt_s.cmt_pdst = h.pnew;
      if (h.exc)
      begin
        // Excepting write dropped; younger work discarded
        for (int i = 0; i < NA; i++)
          used[s_ff.cmap[i]] = 1'b1;
        nxt_s.map = s_ff.cmap;
        nxt_s.free = ~used;
        nxt_s.pready = '1;
        nxt_s.rob = '0;
        nxt_s.head = '0;
        nxt_s.tail = '0;
        nxt_s.cnt = '0;
        nxt_s.s0 = '0;
        nxt_s.s1 = '0;
        nxt_s.flush = 1'b1;
        x_go = 1'b0;
        y_go = 1'b0;
      end
      else
      begin
        // old copy freed once successor commits
        if (h.wr)
        begin
          nxt_s.cmap[h.lreg] = h.pnew;
          nxt_s.free[h.pold] = 1'b1;
        end
        nxt_s.rob[s_ff.head] = '0;
        nxt_s.head = s_ff.head + 1'b1;
        nxt_s.cnt = nxt_s.cnt - 1'b1;
      end
    end

    // X always takes the oldest staged instruction
    if (x_go)
    begin
      nxt_s.x_issue = 1'b1;
      nxt_s.x_tag = s_ff.tail;
      nxt_s.x_pdst = xd;
      nxt_s.x_psa = xa;
      nxt_s.x_psb = xb;
      // both pipes assist the exclusive instruction
      nxt_s.x_excl = is_excl(x.kind);
      nxt_s.rob[s_ff.tail] = {1'b1, 1'b0, 1'b0, x.dst_vld, x.dst, xd,
        s_ff.map[x.dst]};
      if (x.dst_vld)
      begin
        nxt_s.free[xd] = 1'b0;
        nxt_s.pready[xd] = 1'b0;
        nxt_s.map[x.dst] = xd;
      end
      nxt_s.tail = t1;
      nxt_s.cnt = nxt_s.cnt + 1'b1;
      nxt_s.s0 = s_ff.s1;
      nxt_s.s1 = '0;
    end

    if (y_go)
    begin
      nxt_s.y_issue = 1'b1;
      nxt_s.y_tag = t1;
      nxt_s.y_pdst = yd;
      // forwarded source reads the X destination register
      nxt_s.y_psa = dep_a ? xd : ya;
      nxt_s.y_psb = dep_b ? xd : yb;
      nxt_s.y_opfwd = opf;
      nxt_s.y_resfwd = resf;
      // distinct destinations, so completion order is free
      nxt_s.rob[t1] = {1'b1, 1'b0, 1'b0, y.dst_vld, y.dst, yd,
        nxt_s.map[y.dst]};
      if (y.dst_vld)
      begin
        nxt_s.free[yd] = 1'b0;
        nxt_s.pready[yd] = 1'b0;
        nxt_s.map[y.dst] = yd;
      end
      nxt_s.tail = s_ff.tail + 2'h2;
      nxt_s.cnt = nxt_s.cnt + 1'b1;
      nxt_s.s0 = '0;
    end

    // Staging accepts a new pair only when empty; flush cycle drops it
    if (s_ff.rdy && i_pair_valid && !nxt_s.flush)
    begin
      nxt_s.s0 = i_slot0;
      nxt_s.s1 = i_slot1;
    end
    nxt_s.rdy = !nxt_s.s0.vld && !nxt_s.s1.vld;
  end

  // Single state register; identity mapping after reset
  // thirty-two physical registers
  always_ff @(posedge i_clk or posedge i_rst)
  begin
    if (i_rst)
    begin
      s_ff <= '0;
      s_ff.rdy <= 1'b1;
      s_ff.free <= `DPC_RST_FREE_MASK;
      s_ff.pready <= '1;
      for (int i = 0; i < NA; i++)
      begin
        s_ff.map[i] <= PW'(i);
        s_ff.cmap[i] <= PW'(i);
      end
    end
    else
      s_ff <= nxt_s;
  end

  // only per-op tags, physical register numbers, the committed logical register and flags leave; no mapping state is exposed
  assign o_ready = s_ff.rdy;
  assign o_x_issue = s_ff.x_issue;
  assign o_x_tag = s_ff.x_tag;
  assign o_x_pdst = s_ff.x_pdst;
  assign o_x_psrc_a = s_ff.x_psa;
  assign o_x_psrc_b = s_ff.x_psb;
  assign o_x_excl = s_ff.x_excl;
  assign o_y_issue = s_ff.y_issue;
  assign o_y_tag = s_ff.y_tag;
  assign o_y_pdst = s_ff.y_pdst;
  assign o_y_psrc_a = s_ff.y_psa;
  assign o_y_psrc_b = s_ff.y_psb;
  assign o_y_opfwd = s_ff.y_opfwd;
  assign o_y_resfwd = s_ff.y_resfwd;
  assign o_cmt_valid = s_ff.cmt_valid;
  assign o_cmt_wr = s_ff.cmt_wr;
  assign o_cmt_lreg = s_ff.cmt_lreg;
  assign o_cmt_pdst = s_ff.cmt_pdst;
  assign o_cmt_exc = s_ff.cmt_exc;
  assign o_flush = s_ff.flush;

endmodule

`default_nettype wire

/* File: tb/dpc_dual_pipe_ctrl_chk.sv */
/*
  Checker for the dual pipe control: pairing, issue order and commits.
  Assumes a bind onto the control that hands on its parameters.
*/
`default_nettype none
module dpc_dual_pipe_ctrl_chk #(
  parameter int NPHYS = 32,
  parameter int DEPTH = 8
) (
  input wire logic i_clk,
  input wire logic i_rst,
  input wire logic i_pair_valid,
  input wire logic o_ready,
  input wire logic o_x_issue,
  input wire logic [$clog2(DEPTH)-1:0] o_x_tag,
  input wire logic o_x_excl,
  input wire logic o_y_issue,
  input wire logic [$clog2(DEPTH)-1:0] o_y_tag,
  input wire logic o_cmt_valid,
  input wire logic o_cmt_wr,
  input wire logic o_cmt_exc,
  input wire logic o_flush
);
  timeunit 1ns;
  timeprecision 1ns;
  int unsigned live_ff;

  default clocking cb @(posedge i_clk);
  endclocking
  default disable iff (i_rst);

  // Ops in the window; a flush drops all of them at once
  always_ff @(posedge i_clk or posedge i_rst)
  begin
    if (i_rst)
      live_ff <= 0;
    else if (o_flush)
      live_ff <= 0;
    else
      live_ff <= live_ff + o_x_issue + o_y_issue - o_cmt_valid;
  end

  a_y_with_x: assert property (o_y_issue |-> o_x_issue)
    else $error("Y issued without an X partner");
  a_excl_alone: assert property (o_x_issue && o_x_excl |-> !o_y_issue)
    else $error("Exclusive op issued with a Y partner");
  a_issue_staged: assert property (o_x_issue |-> !$past(o_ready))
    else $error("Issue without a staged pair");
  a_ready_drops: assert property (
    o_ready && i_pair_valid |=> !o_ready || o_flush)
    else $error("Ready stayed high after a take");
  a_pair_order: assert property (
    o_y_issue |-> o_y_tag == o_x_tag + 1'b1)
    else $error("Y tag not younger than X tag");
  a_cmt_live: assert property (o_cmt_valid |-> live_ff != 0)
    else $error("Commit with an empty window");
  a_window_cap: assert property (live_ff <= DEPTH)
    else $error("Window holds more ops than its depth");
  a_flush_exc: assert property (o_flush |-> o_cmt_valid && o_cmt_exc)
    else $error("Flush without an exception commit");
  a_exc_no_wr: assert property (
    o_cmt_valid && o_cmt_exc |-> !o_cmt_wr)
    else $error("Excepting op still writes");
endmodule
`default_nettype wire

/* File: tb/dpc_exec_model.sv */
/*
  Execute unit model for one pipe: finishes issued ops in arrival
  order after a random short delay, with an exception on request.
  Assumes the bench raises the request while one op is in flight.
*/
`default_nettype none
module dpc_exec_model (
  input wire logic i_clk,
  input wire logic i_rst,
  input wire logic i_issue,
  input wire logic [2:0] i_tag,
  input wire logic i_flush,
  input wire logic i_exc_req,
  output logic o_done,
  output logic [2:0] o_tag,
  output logic o_exc
);
  timeunit 1ns;
  timeprecision 1ns;
  logic [2:0] pend[$];
  int delay_c;

  initial
  begin
    o_done = 1'b0;
    o_tag = 3'h0;
    o_exc = 1'b0;
    delay_c = 0;
  end

  // Take issued work; a flush throws away everything in flight
  always @(posedge i_clk)
  begin
    if (i_rst || i_flush)
      pend.delete();
    else if (i_issue)
      pend.push_back(i_tag);
  end

  // Random delays per pipe let the pipes finish out of order
  always @(negedge i_clk)
  begin
    if (delay_c == 0 && pend.size() > 0)
    begin
      o_done <= 1'b1;
      o_tag <= pend.pop_front();
      o_exc <= i_exc_req;
      delay_c <= $urandom_range(3);
    end
    else
    begin
      o_done <= 1'b0;
      o_tag <= ~o_tag; // Stale tag must not look valid
      o_exc <= ~o_exc;
      delay_c <= (delay_c > 0) ? delay_c - 1 : 0;
    end
  end
endmodule
`default_nettype wire

/* File: tb/test_dual_pipe_dependency_control.sv */
/*
  Bench for the dual pipe control: a decode driver offers pairs, two
  execute models finish them, commits are compared in program order.
  Assumes a 100 MHz clock and the checker bound from this file.
*/
`default_nettype none
module test_dual_pipe_dependency_control;
  timeunit 1ns;
  timeprecision 1ns;
  localparam dpc_pkg::dpc_kind_t k_alu = dpc_pkg::DPC_K_ALU;
  localparam dpc_pkg::dpc_kind_t k_mov = dpc_pkg::DPC_K_MOVE;
  logic i_clk, i_rst, vld, rdy, xd, xe, yd, ye, xi, yi, xx, opf, rsf;
  logic cv, cw, ce, fl, xexc, op, rs;
  logic [2:0] xt, yt, xit, yit, cl;
  logic [4:0] xp, xa, yp, ya;
  dpc_pkg::dpc_slot_t s0, s1, ra, rb;
  logic [5:0] expq[$];
  logic [5:0] e;
  int mismatches, samples_checked, cyc;

  dpc_dual_pipe_ctrl dut_u (.i_clk(i_clk), .i_rst(i_rst),
    .i_pair_valid(vld), .i_slot0(s0), .i_slot1(s1), .o_ready(rdy),
    .i_x_done(xd), .i_x_tag(xt), .i_x_exc(xe), .i_y_done(yd),
    .i_y_tag(yt), .i_y_exc(ye), .o_x_issue(xi), .o_x_tag(xit),
    .o_x_pdst(xp), .o_x_psrc_a(xa), .o_x_psrc_b(), .o_x_excl(xx),
    .o_y_issue(yi), .o_y_tag(yit), .o_y_pdst(yp), .o_y_psrc_a(ya),
    .o_y_psrc_b(), .o_y_opfwd(opf), .o_y_resfwd(rsf),
    .o_cmt_valid(cv), .o_cmt_wr(cw), .o_cmt_lreg(cl), .o_cmt_pdst(),
    .o_cmt_exc(ce), .o_flush(fl));
  dpc_exec_model xm_u (.i_clk(i_clk), .i_rst(i_rst), .i_issue(xi),
    .i_tag(xit), .i_flush(fl), .i_exc_req(xexc), .o_done(xd),
    .o_tag(xt), .o_exc(xe));
  dpc_exec_model ym_u (.i_clk(i_clk), .i_rst(i_rst), .i_issue(yi),
    .i_tag(yit), .i_flush(fl), .i_exc_req(1'b0), .o_done(yd),
    .o_tag(yt), .o_exc(ye));

  initial
  begin
    i_clk = 1'b0;
    forever #5 i_clk = ~i_clk;
  end

  task automatic check(logic [15:0] seen, logic [15:0] exp);
    samples_checked++;
    if (seen !== exp)
    begin
      mismatches++;
      $display("CHECK FAILED at %0t: seen %0h expected %0h", $time,
        seen, exp);
    end
  endtask

  task automatic give_verdict;
    $display("Checks %0d, mismatches %0d", samples_checked, mismatches);
    if (mismatches == 0 && samples_checked > 0)
      $display("Test passed");
    else
      $display("Test failed");
    $finish;
  endtask

  // Hang guard, well above the fewer than two thousand cycles the run needs
  always @(posedge i_clk)
  begin
    cyc++;
    if (cyc == 20000)
    begin
      mismatches++;
      give_verdict();
    end
  end

  // Commit watcher: oldest note first, an exception drops the rest
  always @(negedge i_clk)
  begin
    if (!i_rst && cv)
    begin
      e = (expq.size() > 0) ? expq.pop_front() : 6'h20;
      check({1'b0, ce, cw, cw ? cl : 3'h0}, e);
      if (ce)
        expq.delete();
    end
  end

  function automatic dpc_pkg::dpc_slot_t mk(dpc_pkg::dpc_kind_t k,
    logic [2:0] d, logic [1:0] dw, logic a, logic [2:0] sa,
    logic [1:0] sw);
    mk = {1'b1, k, 1'b1, d, dw, a, sa, sw, 4'h0};
  endfunction

  // Offer one pair, note its commits, wait for the X issue
  task automatic offer(dpc_pkg::dpc_slot_t a, dpc_pkg::dpc_slot_t b,
    logic [1:0] ey, logic [2:0] ef, logic ex);
    int n;
    n = 0;
    // An expected pairing needs window room, so empty the window first
    if (ey[1])
      drain();
    while (!rdy)
      @(negedge i_clk);
    s0 = a;
    s1 = b;
    vld = 1'b1;
    expq.push_back({1'b0, ex, !ex, ex ? 3'h0 : a.dst});
    if (b.vld)
      expq.push_back({3'b001, b.dst});
    @(negedge i_clk);
    vld = 1'b0;
    s0 = ~a;
    s1 = ~b;
    while (!xi && n < 200)
    begin
      @(negedge i_clk);
      n++;
    end
    check(xi, 1'b1);
    if (ey[1])
      check(yi, ey[0]);
    if (ef[2])
      check({opf, rsf}, ef[1:0]);
    if (ef[2] && ef[1:0] != 2'b00)
      check(ya, xp);
  endtask

  task automatic drain;
    int n;
    n = 0;
    while (expq.size() > 0 && n < 500)
    begin
      @(negedge i_clk);
      n++;
    end
    check(16'(expq.size()), 16'h0000);
  endtask

  initial
  begin
    i_rst = 1'b1;
    vld = 1'b0;
    s0 = '0;
    s1 = '0;
    xexc = 1'b0;
    mismatches = 0;
    samples_checked = 0;
    cyc = 0;
    void'($urandom(87070));
    repeat (5) @(negedge i_clk);
    i_rst = 1'b0;
    check(rdy, 1'b1);
    // Same destination in both pipes, no stall, fresh registers
    offer(mk(k_alu, 0, 2, 1, 1, 2), mk(k_mov, 0, 2, 1, 1, 2), 2'b11, 0, 0);
    check(xp, 5'h08);
    check(yp, 5'h09);
    drain();
    offer(mk(k_alu, 1, 2, 1, 0, 2), '0, 2'b00, 0, 0);
    check(xa, 5'h09);
    offer(mk(k_mov, 3, 2, 1, 1, 2), mk(k_alu, 1, 2, 1, 1, 2), 2'b11, 0, 0);
    $display("renaming done");
    // Read-after-write pairs: forwarding kinds, widths, memory source
    for (int i = 0; i < 5; i++)
    begin
      op = (i == 0 || i == 4);
      rs = (i == 2);
      offer(mk(i < 2 || i == 4 ? k_mov : k_alu, 2, 1, i != 4, 5, 1),
        mk(rs ? k_mov : k_alu, 6, 1, 1, 2, i == 1 ? 2 : 1),
        {1'b1, op || rs}, {op || rs, op, rs}, 0);
    end
    $display("forwarding done");
    for (int k = 2; k <= 10; k++)
    begin
      offer(mk(dpc_pkg::dpc_kind_t'(k), 4, 2, 0, 0, 2),
        mk(k_alu, 5, 2, 0, 0, 2), {1'b1, k < 4}, 0, 0);
      check(xx, k >= 4);
      offer(mk(k_alu, 4, 2, 0, 0, 2),
        mk(dpc_pkg::dpc_kind_t'(k), 5, 2, 0, 0, 2), 2'b10, 0, 0);
    end
    $display("steering done");
    drain();
    xexc = 1'b1;
    offer(mk(k_alu, 6, 2, 0, 0, 2), mk(k_alu, 7, 2, 0, 0, 2), 2'b11, 0, 1);
    drain();
    xexc = 1'b0;
    offer(mk(k_alu, 6, 2, 1, 7, 2), '0, 2'b00, 0, 0);
    $display("exception done");
    for (int i = 0; i < 60; i++)
    begin
      ra = mk(dpc_pkg::dpc_kind_t'($urandom_range(1)), 3'($urandom),
        2'($urandom), 1'($urandom), 3'($urandom), 2'($urandom));
      rb = mk(dpc_pkg::dpc_kind_t'($urandom_range(1)), 3'($urandom),
        2'($urandom), 1'($urandom), 3'($urandom), 2'($urandom));
      rb.vld = 1'($urandom);
      offer(ra, rb, 2'b00, 0, 0);
    end
    drain();
    $display("random done");
    give_verdict();
  end
endmodule

bind dpc_dual_pipe_ctrl dpc_dual_pipe_ctrl_chk #(.NPHYS(NPHYS),
  .DEPTH(DEPTH)) chk_u (.i_clk(i_clk), .i_rst(i_rst),
  .i_pair_valid(i_pair_valid), .o_ready(o_ready),
  .o_x_issue(o_x_issue), .o_x_tag(o_x_tag), .o_x_excl(o_x_excl),
  .o_y_issue(o_y_issue), .o_y_tag(o_y_tag), .o_cmt_valid(o_cmt_valid),
  .o_cmt_wr(o_cmt_wr), .o_cmt_exc(o_cmt_exc), .o_flush(o_flush));
`default_nettype wire
